//--- hdl/rcg_pkg.sv
// Constants and carrier types for the RAM check-code guard.
// Assumes one core clock and a single-port RAM with one-cycle read latency.
package rcg_pkg;

    // Check code.
    localparam int          CRC_W    = 8;
    localparam logic [7:0]  CRC_POLY = 8'h07;
    localparam logic [7:0]  CRC_INIT = 8'hFF;
    localparam int          DBE_FULL_W = 128;

    // Register byte offsets on the APB port.
    localparam logic [11:0] OFF_MECH_EN  = 12'h000;
    localparam logic [11:0] OFF_STATUS   = 12'h004;
    localparam logic [11:0] OFF_CTRL     = 12'h008;
    localparam logic [11:0] OFF_CRC_CNT  = 12'h00C;
    localparam logic [11:0] OFF_PAR_CNT  = 12'h010;
    localparam logic [11:0] OFF_LAST_SYN = 12'h014;

    // Mechanism enable write layout.
    localparam int MECH_ID_LSB  = 24;
    localparam int MECH_BLK_LSB = 8;
    localparam int MECH_EN_BIT  = 0;

    // Status register layout.
    localparam int ST_IDLE_BIT = 0;
    localparam int ST_EN_BIT   = 1;
    localparam int ST_FHI_BIT  = 2;

    // Control register layout and reset values.
    localparam int   CTRL_FHI_BIT   = 0;
    localparam logic MECH_EN_RESET  = 1'b1;
    localparam logic SEL_FHI_RESET  = 1'b0;
    localparam logic IDLE_RESET     = 1'b1;

    // Counter width of the fault counters.
    localparam int CNT_W = 16;

    // Report towards the fault management records.
    typedef struct packed {
        logic       valid;
        logic       correctable;
        logic       to_fhi;
        logic [7:0] safety_mechanism_id;
        logic [7:0] target_block_id;
    } rcg_fmu_rec_t;

    // Report towards the legacy error records.
    typedef struct packed {
        logic       valid;
        logic       correctable;
        logic       crc_fail;
        logic       parity_fail;
        logic [7:0] implementation_error_code;
    } rcg_legacy_rec_t;

endpackage : rcg_pkg

//--- hdl/rcg_ram_crc_guard.sv
// RAM check-code guard: writes, reads, fault flagging, correction and
// reporting for one protected RAM, with an APB register port.
// Assumes the RAM returns read data one cycle after the read request.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps

module rcg_ram_crc_guard #(
    parameter int         DATA_W      = 64,
    parameter int         ADDR_W      = 10,
    parameter logic [7:0] MECH_ID     = 8'h07,
    parameter logic [7:0] BLOCK_ID    = 8'h00,
    parameter bit         IS_CACHE    = 1'b1
) (
    // Clock and reset.
    input  wire logic                      clock,
    input  wire logic                      nrst,
    // Block power-up pulse.
    input  wire logic                      blk_power_up,
    // APB slave.
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // User access.
    input  wire logic                      usr_wr_en,
    input  wire logic                      usr_rd_en,
    input  wire logic [ADDR_W-1:0]         usr_addr,
    input  wire logic [DATA_W-1:0]         usr_wdata,
    output logic      [DATA_W-1:0]         usr_rdata,
    output logic                           usr_rvalid,
    // RAM macro.
    output logic                           ram_en,
    output logic                           ram_we,
    output logic      [ADDR_W-1:0]         ram_addr,
    output logic      [DATA_W+7:0]         ram_wdata,
    input  wire logic [DATA_W+7:0]         ram_rdata,
    input  wire logic                      ram_parity_err,
    // Fault outputs.
    output logic                           crc_fault,
    output logic                           inval_req,
    output logic      [ADDR_W-1:0]         inval_addr,
    output rcg_pkg::rcg_fmu_rec_t          fmu_rec,
    output rcg_pkg::rcg_legacy_rec_t       legacy_rec
);

    localparam int CW = rcg_pkg::CRC_W;
    localparam int NW = rcg_pkg::CNT_W;

    // Serial CRC over address then data, one fixed polynomial for both
    // directions so the write and read codes always agree.
    function automatic logic [7:0] crc_calc(
        input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d
    );
        logic [ADDR_W+DATA_W-1:0] msg;
        logic [7:0]               c;
        logic                     fb;
        msg = {a, d};
        c   = rcg_pkg::CRC_INIT;
        for (int i = ADDR_W + DATA_W - 1; i >= 0; i--) begin
            fb = c[7] ^ msg[i];
            c  = {c[6:0], 1'b0};
            if (fb) begin
                c = c ^ rcg_pkg::CRC_POLY;
            end
        end
        return c;
    endfunction

    // Write path.
    wire logic [CW-1:0] wr_code = crc_calc(usr_addr, usr_wdata);

    assign ram_en    = usr_wr_en | usr_rd_en;
    assign ram_we    = usr_wr_en;
    assign ram_addr  = usr_addr;
    assign ram_wdata = {wr_code, usr_wdata};

    // Read path state.
    logic                 rd_pend_q;
    logic [ADDR_W-1:0]    rd_addr_q;
    logic                 rvalid_q;
    logic [ADDR_W-1:0]    raddr_q;
    logic [DATA_W-1:0]    rdata_q;
    logic [CW-1:0]        rcode_q;
    logic                 rpar_q;

    wire logic rd_issue = usr_rd_en & ~usr_wr_en;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_pend_q <= 1'b0;
        end else begin
            rd_pend_q <= rd_issue;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_addr_q <= '0;
        end else begin
            rd_addr_q <= usr_addr;
        end
    end

    // Data returned by the RAM is captured with the address used to read it.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_pend_q;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            raddr_q <= '0;
        end else begin
            raddr_q <= rd_addr_q;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= ram_rdata[DATA_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rcode_q <= '0;
        end else begin
            rcode_q <= ram_rdata[DATA_W+7:DATA_W];
        end
    end

    // Parity is only meaningful in the cycle the RAM answers a read.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rpar_q <= 1'b0;
        end else begin
            rpar_q <= rd_pend_q & ram_parity_err;
        end
    end

    // Faulty data is forwarded unchanged whatever the RAM type.
    assign usr_rdata  = rdata_q;
    assign usr_rvalid = rvalid_q;

    // Check on the read-data-valid cycle only.
    wire logic [CW-1:0] rd_code  = crc_calc(raddr_q, rdata_q);
    wire logic [CW-1:0] syndrome = rd_code ^ rcode_q;
    wire logic crc_bad  = rvalid_q & (syndrome != '0);
    wire logic par_bad  = rvalid_q & rpar_q;

    assign crc_fault = crc_bad;

    // Correction: cache RAMs invalidate the failing location.
    wire logic corr_ram = IS_CACHE;
    assign inval_req  = corr_ram & (crc_bad | par_bad);
    assign inval_addr = raddr_q;

    // Software state.
    logic           mech_en_q;
    logic           sel_fhi_q;
    logic           idle_q;
    logic [NW-1:0]  crc_cnt_q;
    logic [NW-1:0]  par_cnt_q;
    logic [CW-1:0]  last_syn_q;

    // Register decode, shared by every offset compare.
    function automatic logic reg_hit(
        input logic [11:0] a,
        input logic [11:0] off
    );
        return a == off;
    endfunction

    // APB decode.
    wire logic apb_acc   = psel & penable;
    wire logic apb_wr    = apb_acc & pwrite;
    wire logic hit_mech  = reg_hit(paddr, rcg_pkg::OFF_MECH_EN);
    wire logic hit_stat  = reg_hit(paddr, rcg_pkg::OFF_STATUS);
    wire logic hit_ctrl  = reg_hit(paddr, rcg_pkg::OFF_CTRL);
    wire logic hit_ccnt  = reg_hit(paddr, rcg_pkg::OFF_CRC_CNT);
    wire logic hit_pcnt  = reg_hit(paddr, rcg_pkg::OFF_PAR_CNT);
    wire logic hit_syn   = reg_hit(paddr, rcg_pkg::OFF_LAST_SYN);
    wire logic hit_any   = hit_mech | hit_stat | hit_ctrl | hit_ccnt
                         | hit_pcnt | hit_syn;

    // The enable write only acts when it names this mechanism and block.
    wire logic [7:0] wr_mech_id =
        pwdata[rcg_pkg::MECH_ID_LSB+7:rcg_pkg::MECH_ID_LSB];
    wire logic [7:0] wr_blk_id =
        pwdata[rcg_pkg::MECH_BLK_LSB+7:rcg_pkg::MECH_BLK_LSB];
    wire logic mech_wr = apb_wr & hit_mech;
    wire logic mech_match = (wr_mech_id == MECH_ID)
                          & (wr_blk_id == BLOCK_ID);

    // Enable register comes up set and is set again on block power-up.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mech_en_q <= rcg_pkg::MECH_EN_RESET;
        end else if (blk_power_up) begin
            mech_en_q <= rcg_pkg::MECH_EN_RESET;
        end else if (mech_wr && mech_match) begin
            mech_en_q <= pwdata[rcg_pkg::MECH_EN_BIT];
        end
    end

    // Idle drops for the cycle after an enable write, then returns.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            idle_q <= rcg_pkg::IDLE_RESET;
        end else begin
            idle_q <= ~mech_wr;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sel_fhi_q <= rcg_pkg::SEL_FHI_RESET;
        end else if (apb_wr && hit_ctrl) begin
            sel_fhi_q <= pwdata[rcg_pkg::CTRL_FHI_BIT];
        end
    end

    // Saturating fault counters and last syndrome for diagnosis.
    wire logic crc_sat = &crc_cnt_q;
    wire logic par_sat = &par_cnt_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            crc_cnt_q <= '0;
        end else if (crc_bad && !crc_sat) begin
            crc_cnt_q <= crc_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            par_cnt_q <= '0;
        end else if (par_bad && !par_sat) begin
            par_cnt_q <= par_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            last_syn_q <= '0;
        end else if (crc_bad) begin
            last_syn_q <= syndrome;
        end
    end

    // Fault record: code failures only, gated by the enable, any RAM type, mechanism and block ids.
    rcg_pkg::rcg_fmu_rec_t    fmu_d;
    rcg_pkg::rcg_legacy_rec_t leg_d;

    // Report triggers, kept apart so each gating is visible on its own.
    wire logic fmu_fire = crc_bad & mech_en_q;
    wire logic leg_fire = corr_ram & (crc_bad | par_bad);

    always_comb begin
        fmu_d = '0;
        fmu_d.valid = fmu_fire;
        fmu_d.correctable = corr_ram;
        fmu_d.to_fhi = sel_fhi_q;
        fmu_d.safety_mechanism_id = MECH_ID;
        fmu_d.target_block_id = BLOCK_ID;
    end

    // Legacy record: correctable RAMs only, code or parity, never gated.
    always_comb begin
        leg_d = '0;
        leg_d.valid = leg_fire;
        leg_d.correctable = 1'b1;
        leg_d.crc_fail = crc_bad;
        leg_d.parity_fail = par_bad;
        leg_d.implementation_error_code = syndrome;
    end

    // Records leave from flops, one cycle after the read answer that flags the fault.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fmu_rec <= '0;
        end else begin
            fmu_rec <= fmu_d;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            legacy_rec <= '0;
        end else begin
            legacy_rec <= leg_d;
        end
    end

    // Read words, one per readable register.
    wire logic [31:0] stat_word = {29'h0000000, sel_fhi_q, mech_en_q,
                                   idle_q};
    wire logic [31:0] ctrl_word = {31'h00000000, sel_fhi_q};
    wire logic [31:0] ccnt_word = {{(32-NW){1'b0}}, crc_cnt_q};
    wire logic [31:0] pcnt_word = {{(32-NW){1'b0}}, par_cnt_q};
    wire logic [31:0] syn_word  = {24'h000000, last_syn_q};

    // APB read mux.
    wire logic [31:0] rd_mux =
          hit_stat ? stat_word
        : hit_ctrl ? ctrl_word
        : hit_ccnt ? ccnt_word
        : hit_pcnt ? pcnt_word
        : hit_syn  ? syn_word
        : 32'h00000000;

    assign prdata  = rd_mux;
    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~hit_any;

endmodule // rcg_ram_crc_guard

//--- dv/rcg_ram_crc_guard_properties.sv
// Port assertions for the RAM check-code guard.
// Assumes a RAM that answers one cycle after each read request.
`timescale 1ns/1ps
module rcg_ram_crc_guard_chk #(
    parameter int         DATA_W   = 64,
    parameter int         ADDR_W   = 10,
    parameter logic [7:0] MECH_ID  = 8'h07,
    parameter logic [7:0] BLOCK_ID = 8'h00,
    parameter bit         IS_CACHE = 1'b1
) (
    // Clock and reset.
    input wire logic                     clock,
    input wire logic                     nrst,
    // User side.
    input wire logic                     usr_wr_en,
    input wire logic                     usr_rd_en,
    input wire logic [ADDR_W-1:0]        usr_addr,
    input wire logic [DATA_W-1:0]        usr_wdata,
    input wire logic [DATA_W-1:0]        usr_rdata,
    input wire logic                     usr_rvalid,
    // RAM side.
    input wire logic                     ram_en,
    input wire logic                     ram_we,
    input wire logic [ADDR_W-1:0]        ram_addr,
    input wire logic [DATA_W+7:0]        ram_wdata,
    input wire logic [DATA_W+7:0]        ram_rdata,
    input wire logic                     ram_parity_err,
    // Faults.
    input wire logic                     crc_fault,
    input wire logic                     inval_req,
    input wire logic [ADDR_W-1:0]        inval_addr,
    input wire rcg_pkg::rcg_fmu_rec_t    fmu_rec,
    input wire rcg_pkg::rcg_legacy_rec_t legacy_rec
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence s_read; usr_rd_en && !usr_wr_en; endsequence
    sequence s_fault; usr_rvalid && crc_fault; endsequence

    rvalid_timing_a: assert property (s_read |-> ##2 usr_rvalid)
        else $error("read answer missing");
    rvalid_cause_a: assert property (usr_rvalid |->
        $past(usr_rd_en && !usr_wr_en, 2)) else $error("stray answer");
    fault_on_valid_a: assert property (crc_fault |-> usr_rvalid)
        else $error("fault outside read answer");
    inval_cause_a: assert property (usr_rvalid |-> inval_req == (IS_CACHE
        && (crc_fault || $past(ram_parity_err)))) else $error("bad inval");
    inval_addr_a: assert property (inval_req |-> inval_addr ==
        $past(usr_addr, 2)) else $error("wrong inval address");
    rdata_pass_a: assert property (usr_rvalid |-> usr_rdata ==
        $past(ram_rdata[DATA_W-1:0])) else $error("data altered");
    fmu_record_a: assert property (fmu_rec.valid |-> $past(crc_fault)
        && fmu_rec.correctable == IS_CACHE && fmu_rec.safety_mechanism_id ==
        MECH_ID && fmu_rec.target_block_id == BLOCK_ID) else $error("bad fmu");
    legacy_follow_a: assert property (legacy_rec.valid == $past(inval_req))
        else $error("legacy record mismatch");
    legacy_crc_a: assert property (s_fault |=> legacy_rec.crc_fail)
        else $error("legacy crc flag missing");
    write_path_a: assert property (usr_wr_en |-> ram_en && ram_we && ram_addr
        == usr_addr && ram_wdata[DATA_W-1:0] == usr_wdata) else $error("wr");
endmodule // rcg_ram_crc_guard_chk

bind rcg_ram_crc_guard rcg_ram_crc_guard_chk #(.DATA_W(DATA_W),
    .ADDR_W(ADDR_W), .MECH_ID(MECH_ID), .BLOCK_ID(BLOCK_ID),
    .IS_CACHE(IS_CACHE)) i_rcg_ram_crc_guard_chk (.clock, .nrst, .usr_wr_en,
    .usr_rd_en, .usr_addr, .usr_wdata, .usr_rdata, .usr_rvalid, .ram_en,
    .ram_we, .ram_addr, .ram_wdata, .ram_rdata, .ram_parity_err, .crc_fault,
    .inval_req, .inval_addr, .fmu_rec, .legacy_rec);

//--- dv/rcg_ram_model.sv
// Single-port RAM model with one-cycle read latency and fault injection.
// Assumes the bench sets the flip mask and parity flag with each read.
`timescale 1ns/1ps
module rcg_ram_model #(
    parameter int DW = 16,
    parameter int AW = 4
) (
    // Clock.
    input  wire logic          clock,
    // Port from the guard.
    input  wire logic          ram_en,
    input  wire logic          ram_we,
    input  wire logic [AW-1:0] ram_addr,
    input  wire logic [DW+7:0] ram_wdata,
    // Fault injection.
    input  wire logic [DW+7:0] flip,
    input  wire logic          perr,
    // Read answer.
    output logic      [DW+7:0] ram_rdata,
    output logic               ram_parity_err
);
    logic [DW+7:0] mem [2**AW];
    initial begin
        ram_rdata = '0;
        ram_parity_err = 1'b0;
    end
    // Outside a read answer the outputs toggle so stale data never looks valid.
    always @(posedge clock) begin
        if (ram_en && ram_we) begin
            mem[ram_addr] <= ram_wdata;
        end
        if (ram_en && !ram_we) begin
            ram_rdata      <= mem[ram_addr] ^ flip;
            ram_parity_err <= perr;
        end else begin
            ram_rdata      <= ~ram_rdata;
            ram_parity_err <= ~ram_parity_err;
        end
    end
endmodule // rcg_ram_model

//--- dv/tb.sv
// Self-checking bench for the RAM check-code guard.
// Assumes the RAM model answers reads one cycle after the request.
`timescale 1ns/1ps
module tb;
    localparam int DW = 16;
    localparam int AW = 4;
    logic clock = 0, nrst = 0, blk_power_up = 0, perr = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic usr_wr_en = 0, usr_rd_en = 0, usr_rvalid, crc_fault, inval_req;
    logic [AW-1:0] usr_addr = '0, inval_addr, ram_addr;
    logic [DW-1:0] usr_wdata = '0, usr_rdata, mem_exp [2**AW];
    logic ram_en, ram_we, ram_parity_err, en_exp = 1, fhi_exp = 0;
    logic [DW+7:0] ram_wdata, ram_rdata, flip = '0;
    rcg_pkg::rcg_fmu_rec_t fmu_rec;
    rcg_pkg::rcg_legacy_rec_t legacy_rec;
    int err_count = 0, checks_done = 0, cyc = 0, crc_n = 0;

    rcg_ram_crc_guard #(.DATA_W(DW), .ADDR_W(AW)) i_rcg_ram_crc_guard (
        .clock, .nrst, .blk_power_up, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .usr_wr_en, .usr_rd_en,
        .usr_addr, .usr_wdata, .usr_rdata, .usr_rvalid, .ram_en, .ram_we,
        .ram_addr, .ram_wdata, .ram_rdata, .ram_parity_err, .crc_fault,
        .inval_req, .inval_addr, .fmu_rec, .legacy_rec);
    rcg_ram_model #(.DW(DW), .AW(AW)) i_rcg_ram_model (.clock, .ram_en,
        .ram_we, .ram_addr, .ram_wdata, .flip, .perr, .ram_rdata,
        .ram_parity_err);

    always #20 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            err_count++;
            wrap_up();
        end
    end

    function automatic logic [7:0] crc(logic [AW-1:0] a, logic [DW-1:0] d);
        logic [AW+DW-1:0] v;
        logic [7:0] c;
        v = {a, d};
        c = rcg_pkg::CRC_INIT;
        for (int i = AW + DW - 1; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? rcg_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %0h want %0h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clock);
        penable <= 1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clock);
        {usr_wr_en, usr_addr, usr_wdata} <= {1'b1, a, d};
        @(posedge clock);
        chk(32'(ram_wdata), 32'({crc(a, d), d}));
        usr_wr_en <= 0;
        mem_exp[a] = d;
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [DW+7:0] m,
                      input logic p);
        logic [DW-1:0] dd;
        logic [7:0] cc;
        logic f;
        dd = mem_exp[a] ^ m[DW-1:0];
        cc = crc(a, mem_exp[a]) ^ m[DW+7:DW];
        f = crc(a, dd) != cc;
        if (f) crc_n++;
        @(posedge clock);
        {usr_rd_en, usr_addr, flip, perr} <= {1'b1, a, m, p};
        @(posedge clock);
        usr_rd_en <= 0;
        @(posedge clock);
        #1;
        chk(32'(usr_rdata), 32'(dd));
        chk({usr_rvalid, crc_fault, inval_req}, {1'b1, f, f | p});
        @(posedge clock);
        #1;
        chk(fmu_rec.valid, f & en_exp);
        if (f & en_exp) chk(fmu_rec, {2'b11, fhi_exp, 16'h0700});
        chk(legacy_rec.valid, f | p);
        if (f | p) chk(legacy_rec, {2'b11, f, p, crc(a, dd) ^ cc});
    endtask

    task automatic wrap_up();
        $display("Mismatches %0d in %0d checks", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        void'($urandom(84));
        repeat (3) @(posedge clock);
        nrst <= 1;
        apb(0, 12'h004, 0);
        chk(r, 32'h3);
        for (int i = 0; i < 16; i++) wr(AW'(i), DW'($urandom));
        for (int i = 0; i < 16; i++) rd(AW'(i), '0, 0);
        for (int b = 0; b < DW + 8; b++) rd(AW'($urandom), 24'h1 << b, 0);
        repeat (20) rd(AW'($urandom), (24'h1 << ($urandom % 24)) |
                       (24'h1 << ($urandom % 24)), 0);
        rd(3, '0, 1);
        apb(1, 12'h000, 32'h0800_0000);
        apb(0, 12'h004, 0);
        chk(r, 32'h3);
        apb(1, 12'h000, 32'h0700_0000);
        apb(0, 12'h004, 0);
        chk(r, 32'h1);
        en_exp = 0;
        rd(5, 24'h10, 0);
        @(posedge clock);
        blk_power_up <= 1;
        @(posedge clock);
        blk_power_up <= 0;
        en_exp = 1;
        apb(1, 12'h008, 1);
        fhi_exp = 1;
        apb(0, 12'h004, 0);
        chk(r, 32'h7);
        rd(6, 24'h80_0000, 0);
        apb(0, 12'h014, 0);
        chk(r, 32'h80);
        apb(0, 12'h008, 0);
        chk(r, 32'h1);
        apb(0, 12'h00C, 0);
        chk(r, 32'(crc_n));
        apb(0, 12'h010, 0);
        chk(r, 32'h1);
        apb(0, 12'h020, 0);
        chk(e, 1);
        wrap_up();
    end
endmodule // tb
